/* twis_ctrl.v */
// Two-wire multi-master bus controller with register file, status flags and interrupt.
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "twis_consts.vh"

module twis_ctrl (
  input  wire        clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        sclIn,
  output wire        sclOut,
  output wire        sclOe,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe,
  output wire        irq
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_BIT   = 3'd2;
  localparam ST_STOP  = 3'd3;
  localparam ST_RSTRT = 3'd4;

  // Pin synchronisers: three stages, a change counts once stages two and three agree.
  reg  [2:0] sclSync_q;
  reg  [2:0] sdaSync_q;
  reg        scl_q;
  reg        sda_q;
  reg        sclPrev_q;
  reg        sdaPrev_q;

  // Registers.
  reg  [7:0] slaveAddr_q;
  reg  [7:0] bitRate_q;
  reg  [7:0] ctl_q;
  reg  [7:0] ext_q;
  reg  [7:0] txData_q;
  reg  [7:0] rxData_q;
  reg        tcf_q;
  reg        addressed_as_slave_flag_q;
  reg        busy_q;
  reg        arbitration_lost_flag_q;
  reg        srw_q;
  reg        irqf_q;
  reg        received_ack_bit_q;

  // Bus slave.
  reg        wrPend_q;
  reg  [7:0] wrAddr_q;
  reg [31:0] rdData_q;

  // Engine.
  reg  [2:0] state_q;
  reg  [3:0] bitCnt_q;
  reg  [7:0] shift_q;
  reg [13:0] divCnt_q;
  reg        sclDrv_q;
  reg        sdaDrv_q;
  reg        phase_q;
  reg        slvActive_q;
  reg        slvAddrPhase_q;
  reg        slvTenFirst_q;
  reg  [3:0] slvBit_q;
  reg  [7:0] slvShift_q;
  reg        slvAckDrv_q;
  reg        txPend_q;
  reg        prevMaster_q;

  wire       sclRise;
  wire       sclFall;
  wire       startDet;
  wire       stopDet;
  wire       addrPhase;
  wire       wrEnable;
  wire [7:0] wdByte;
  wire [13:0] halfPeriod;
  wire       masterOn;
  wire       masterReq;
  wire       masterDrop;
  wire       arbLoss;
  reg        tcfSet;
  reg        iaasSet;
  reg        arbSet;

  function [5:0] sclDivider;
    input [5:0] icr;
    begin
      sclDivider = icr + 6'h01;
    end
  endfunction

  function [1:0] multOf;
    input [1:0] code;
    begin
      case (code)
        2'h0:    multOf = 2'h1;
        2'h1:    multOf = 2'h2;
        default: multOf = 2'h3;
      endcase
    end
  endfunction

  // Half an SCL period is multiplier times divider bus clocks; the count runs down to zero inclusive.
  assign halfPeriod = ({12'h000, multOf(bitRate_q[7:6])} * {8'h00, sclDivider(bitRate_q[5:0])})
                      - 14'h0001;

  assign sclRise  = scl_q & ~sclPrev_q;
  assign sclFall  = ~scl_q & sclPrev_q;
  assign startDet = scl_q & sclPrev_q & sdaPrev_q & ~sda_q;
  assign stopDet  = scl_q & sclPrev_q & ~sdaPrev_q & sda_q;

  assign addrPhase = hsel & hready & htrans[1];
  assign wrEnable  = wrPend_q;
  assign wdByte    = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_q;

  assign masterOn   = ctl_q[`TWIS_CTL_MASTER];
  assign masterReq  = wrEnable && wrAddr_q == `TWIS_OFF_PRIMARY_CTL &&
                      wdByte[`TWIS_CTL_MASTER] && !masterOn;
  assign masterDrop = wrEnable && wrAddr_q == `TWIS_OFF_PRIMARY_CTL &&
                      !wdByte[`TWIS_CTL_MASTER] && masterOn;

  // Open-drain pins: enable low while the line is pulled low.
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe  = ~sclDrv_q;
  assign sdaOe  = ~(sdaDrv_q | slvAckDrv_q);

  assign irq = irqf_q & ctl_q[`TWIS_CTL_IRQ_EN];

  // Arbitration: engine releases SDA high but bus reads low, on SCL rise.
  assign arbLoss = masterOn && state_q == ST_BIT && sclRise && !sdaDrv_q && !sda_q &&
                   (ctl_q[`TWIS_CTL_TX] ? bitCnt_q != 4'd8 : bitCnt_q == 4'd8);

  always @*
  begin
    arbSet = arbLoss;
    if (masterReq && busy_q)
      arbSet = 1'b1;
    if (wrEnable && wrAddr_q == `TWIS_OFF_PRIMARY_CTL && wdByte[`TWIS_CTL_RSTART] && !masterOn)
      arbSet = 1'b1;
    if (stopDet && masterOn && state_q != ST_STOP)
      arbSet = 1'b1;
    tcfSet  = 1'b0;
    iaasSet = 1'b0;
    // The bit tracker follows every byte on the bus, own master transfers included.
    if (sclFall && slvActive_q && slvBit_q == 4'd8 && (addressed_as_slave_flag_q || masterOn))
      tcfSet = 1'b1;
    if (sclRise && slvActive_q && slvAddrPhase_q && slvBit_q == 4'd7 && !masterOn)
    begin
      if (slvTenFirst_q)
        iaasSet = {slvShift_q[6:0], sda_q} == {slaveAddr_q[7:1], 1'b0} ||
                  ({slvShift_q[6:0], sda_q} == `TWIS_GEN_CALL && ext_q[`TWIS_X_GENERAL_CALL_ENABLE]);
      else if (ext_q[`TWIS_X_TENBIT])
        iaasSet = slvShift_q[6:2] == `TWIS_TEN_PREFIX &&
                  slvShift_q[1:0] == ext_q[2:1];
      else
        iaasSet = slvShift_q[6:0] == slaveAddr_q[7:1] ||
                  (slvShift_q[6:0] == `TWIS_GEN_CALL && ext_q[`TWIS_X_GENERAL_CALL_ENABLE]);
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      slaveAddr_q <= `TWIS_RST_BYTE;
      bitRate_q <= `TWIS_RST_BYTE;
      ctl_q <= `TWIS_RST_BYTE;
      ext_q <= `TWIS_RST_BYTE;
      txData_q <= `TWIS_RST_BYTE;
      rxData_q <= `TWIS_RST_BYTE;
      tcf_q <= 1'b1;
      addressed_as_slave_flag_q <= 1'b0;
      busy_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      srw_q <= 1'b0;
      irqf_q <= 1'b0;
      received_ack_bit_q <= 1'b0;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdData_q <= 32'h00000000;
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      divCnt_q <= 14'h0000;
      sclDrv_q <= 1'b0;
      sdaDrv_q <= 1'b0;
      phase_q <= 1'b0;
      slvActive_q <= 1'b0;
      slvAddrPhase_q <= 1'b0;
      slvTenFirst_q <= 1'b0;
      slvBit_q <= 4'h0;
      slvShift_q <= 8'h00;
      slvAckDrv_q <= 1'b0;
      txPend_q <= 1'b0;
      prevMaster_q <= 1'b0;
    end
    else if (clkEn)
    begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      if (sclSync_q[1] == sclSync_q[2])
        scl_q <= sclSync_q[2];
      if (sdaSync_q[1] == sdaSync_q[2])
        sda_q <= sdaSync_q[2];
      sclPrev_q <= scl_q;
      sdaPrev_q <= sda_q;
      prevMaster_q <= masterOn;

      // AHB-Lite: capture the address phase, act in the data phase.
      wrPend_q <= addrPhase & hwrite;
      if (addrPhase)
        wrAddr_q <= haddr[7:0];
      if (addrPhase && !hwrite)
      begin
        case (haddr[7:0])
          `TWIS_OFF_SLAVE_ADDR:  rdData_q <= {24'h000000, slaveAddr_q[7:1], 1'b0};
          `TWIS_OFF_BIT_RATE:    rdData_q <= {24'h000000, bitRate_q};
          `TWIS_OFF_PRIMARY_CTL: rdData_q <= {24'h000000, ctl_q[7:4], 1'b0, ctl_q[2], 2'b00};
          `TWIS_OFF_STATUS:      rdData_q <= {24'h000000, tcf_q, addressed_as_slave_flag_q, busy_q, arbitration_lost_flag_q, 1'b0,
                                              srw_q, irqf_q, received_ack_bit_q};
          `TWIS_OFF_DATA:        rdData_q <= {24'h000000, rxData_q};
          `TWIS_OFF_ADDR_EXT:    rdData_q <= {24'h000000, ext_q[7:6], 3'b000, ext_q[2:0]};
          default:               rdData_q <= 32'h00000000;
        endcase
        if (haddr[7:0] == `TWIS_OFF_DATA && !ctl_q[`TWIS_CTL_TX])
          txPend_q <= 1'b0;
      end
      if (wrEnable)
      begin
        case (wrAddr_q)
          `TWIS_OFF_SLAVE_ADDR:  slaveAddr_q <= {wdByte[7:1], 1'b0};
          `TWIS_OFF_BIT_RATE:    bitRate_q <= wdByte;
          `TWIS_OFF_PRIMARY_CTL: ctl_q <= {wdByte[7:4], 1'b0, wdByte[2], 2'b00};
          `TWIS_OFF_DATA:
          begin
            txData_q <= wdByte;
            txPend_q <= 1'b1;
          end
          `TWIS_OFF_ADDR_EXT:    ext_q <= {wdByte[7:6], 3'b000, wdByte[2:0]};
          default:               ;
        endcase
      end

      // Sticky flags: set wins over a one-write clear, a zero write keeps them.
      if (wrEnable && wrAddr_q == `TWIS_OFF_STATUS && wdByte[`TWIS_ST_IRQF])
        irqf_q <= 1'b0;
      if (wrEnable && wrAddr_q == `TWIS_OFF_STATUS && wdByte[`TWIS_ST_ARBITRATION_LOST_FLAG])
        arbitration_lost_flag_q <= 1'b0;
      if (tcfSet || iaasSet || arbSet)
        irqf_q <= 1'b1;
      if (arbSet)
        arbitration_lost_flag_q <= 1'b1;

      if (startDet)
        busy_q <= 1'b1;
      else if (stopDet)
        busy_q <= 1'b0;

      // Slave side: shift bus bits, detect address and byte completion.
      if (startDet || stopDet)
      begin
        slvActive_q <= startDet;
        slvAddrPhase_q <= 1'b1;
        slvTenFirst_q <= 1'b0;
        // The SCL fall that closes a start is no bit; it wraps the count to zero.
        slvBit_q <= 4'hf;
        slvAckDrv_q <= 1'b0;
        if (stopDet)
          addressed_as_slave_flag_q <= 1'b0;
      end
      else if (slvActive_q)
      begin
        if (sclRise && slvBit_q < 4'd8)
          slvShift_q <= {slvShift_q[6:0], sda_q};
        if (sclFall)
        begin
          if (slvBit_q == 4'd8)
          begin
            slvBit_q <= 4'h0;
            slvAckDrv_q <= 1'b0;
            if (!masterOn)
              rxData_q <= slvShift_q;
            if (slvAddrPhase_q && addressed_as_slave_flag_q)
              slvTenFirst_q <= ext_q[`TWIS_X_TENBIT] && !slvTenFirst_q;
            slvAddrPhase_q <= slvTenFirst_q ? 1'b0 : (ext_q[`TWIS_X_TENBIT] && addressed_as_slave_flag_q);
            tcf_q <= 1'b1;
          end
          else
          begin
            slvBit_q <= slvBit_q + 4'h1;
            if (slvBit_q == 4'd0)
              tcf_q <= 1'b0;
            if (slvBit_q == 4'd7 && (addressed_as_slave_flag_q || iaasSet) && !masterOn && !srw_q)
              slvAckDrv_q <= 1'b1;
          end
        end
      end
      if (iaasSet)
      begin
        addressed_as_slave_flag_q <= 1'b1;
        srw_q <= sda_q;
      end
      if (sclRise && slvBit_q == 4'd8 && slvActive_q)
        received_ack_bit_q <= sda_q;

      // Master engine.
      if (arbSet)
      begin
        ctl_q[`TWIS_CTL_MASTER] <= 1'b0;
        ctl_q[`TWIS_CTL_TX] <= 1'b0;
        sdaDrv_q <= 1'b0;
        sclDrv_q <= 1'b0;
        state_q <= ST_IDLE;
      end
      else
      begin
        if (divCnt_q != 14'h0000)
          divCnt_q <= divCnt_q - 14'h0001;
        case (state_q)
          ST_IDLE:
            if (masterOn && !prevMaster_q && ctl_q[`TWIS_CTL_ENABLE] && !busy_q)
            begin
              sdaDrv_q <= 1'b1;
              divCnt_q <= halfPeriod;
              state_q <= ST_START;
            end
          ST_START:
            if (divCnt_q == 14'h0000)
            begin
              sclDrv_q <= 1'b1;
              divCnt_q <= halfPeriod;
              bitCnt_q <= 4'h0;
              phase_q <= 1'b0;
              shift_q <= txData_q;
              txPend_q <= 1'b0;
              state_q <= ST_BIT;
            end
          ST_BIT:
            if (divCnt_q == 14'h0000)
            begin
              divCnt_q <= halfPeriod;
              if (!phase_q)
              begin
                if (bitCnt_q == 4'd8)
                  sdaDrv_q <= ctl_q[`TWIS_CTL_TX] ? 1'b0 : 1'b0;
                else
                  sdaDrv_q <= ctl_q[`TWIS_CTL_TX] ? ~shift_q[7] : 1'b0;
                sclDrv_q <= 1'b0;
                phase_q <= 1'b1;
              end
              else if (scl_q)
              begin
                sclDrv_q <= 1'b1;
                phase_q <= 1'b0;
                if (bitCnt_q == 4'd8)
                begin
                  bitCnt_q <= 4'h0;
                  if (!ctl_q[`TWIS_CTL_TX])
                    rxData_q <= shift_q;
                  if (!masterOn)
                    state_q <= ST_STOP;
                  else if (ctl_q[`TWIS_CTL_RSTART])
                    state_q <= ST_RSTRT;
                  shift_q <= ctl_q[`TWIS_CTL_TX] ? txData_q : 8'h00;
                  txPend_q <= 1'b0;
                end
                else
                begin
                  bitCnt_q <= bitCnt_q + 4'h1;
                  shift_q <= {shift_q[6:0], sda_q};
                end
              end
            end
          ST_RSTRT:
          begin
            sdaDrv_q <= 1'b0;
            if (divCnt_q == 14'h0000)
            begin
              ctl_q[`TWIS_CTL_RSTART] <= 1'b0;
              state_q <= ST_IDLE;
              sclDrv_q <= 1'b0;
            end
          end
          ST_STOP:
          begin
            sdaDrv_q <= 1'b1;
            sclDrv_q <= 1'b0;
            if (divCnt_q == 14'h0000 && scl_q)
            begin
              sdaDrv_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          default:
            state_q <= ST_IDLE;
        endcase
        if (masterDrop && state_q == ST_BIT)
        begin
          state_q <= ST_STOP;
          divCnt_q <= halfPeriod;
        end
      end
    end
  end

endmodule // twis_ctrl
`default_nettype wire

/* twis_consts.vh */
// Register offsets, field positions, reset values and timing constants of the two-wire controller.
`ifndef TWIS_CONSTS_VH
`define TWIS_CONSTS_VH
`define TWIS_OFF_SLAVE_ADDR   8'h00
`define TWIS_OFF_BIT_RATE     8'h04
`define TWIS_OFF_PRIMARY_CTL  8'h08
`define TWIS_OFF_STATUS       8'h0c
`define TWIS_OFF_DATA         8'h10
`define TWIS_OFF_ADDR_EXT     8'h14
`define TWIS_CTL_ENABLE       7
`define TWIS_CTL_IRQ_EN       6
`define TWIS_CTL_MASTER       5
`define TWIS_CTL_TX           4
`define TWIS_CTL_RSTART       2
`define TWIS_ST_TCF           7
`define TWIS_ST_ADDRESSED_AS_SLAVE_FLAG          6
`define TWIS_ST_BUSY          5
`define TWIS_ST_ARBITRATION_LOST_FLAG          4
`define TWIS_ST_SRW           2
`define TWIS_ST_IRQF          1
`define TWIS_ST_RECEIVED_ACK_BIT          0
`define TWIS_X_GENERAL_CALL_ENABLE          7
`define TWIS_X_TENBIT         6
`define TWIS_RST_BYTE         8'h00
`define TWIS_MIN_DIV          8'h01
`define TWIS_GEN_CALL         7'h00
`define TWIS_TEN_PREFIX       5'h1e
`endif

/* twis_ctrl_chk.sv */
// Port checker of the two-wire controller.
`timescale 1ns/100ps
`default_nettype none
`include "twis_consts.vh"
module twis_ctrl_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire take = hsel && hready && htrans[1];

  sequence wrTo(logic [7:0] off);
    take && hwrite && haddr[7:0] == off ##1 1'b1;
  endsequence

  a_bus_okay:
    assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bad bus response");
  a_open_drain:
    assert property (sclOut == 1'b0 && sdaOut == 1'b0) else $error("line driven high");
  a_reset_idle:
    assert property ($fell(rst) |-> sdaOe && sclOe && !irq) else $error("not idle after reset");
  a_unmapped_zero:
    assert property (take && !hwrite && haddr[7:0] > `TWIS_OFF_ADDR_EXT |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero:
    assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  a_rdata_holds:
    assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  a_flag_clear:
    assert property (wrTo(`TWIS_OFF_STATUS) ##0 hwdata[1] |=> !irq)
    else $error("flag write did not clear interrupt");
  a_zero_keeps:
    assert property (wrTo(`TWIS_OFF_STATUS) ##0 (!hwdata[1] && irq) |=> irq)
    else $error("zero write cleared flag");
  a_irq_masked:
    assert property (wrTo(`TWIS_OFF_PRIMARY_CTL) ##0 !hwdata[6] |=> !irq)
    else $error("interrupt not masked");
  a_release_lost:
    assert property ($rose(irq) && !sdaOe |-> ##[0:40] sdaOe || !irq)
    else $error("data line kept after event");
endmodule // twis_ctrl_chk
`default_nettype wire

/* twis_peer.sv */
// Behavioural model of another master on the two-wire bus.
`timescale 1ns/100ps
`default_nettype none
module twis_peer (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sclOeN,
  output var  logic sdaOeN
);
  localparam int HALF = 20;
  logic ack;
  // Enables are low while the peer pulls its line low.
  initial
  begin
    sclOeN = 1'b1;
    sdaOeN = 1'b1;
    ack = 1'b1;
  end
  task automatic half();
    repeat (HALF) @(posedge clk);
  endtask
  // Releases the clock and waits out any stretching by the slave.
  task automatic sclUp();
    @(posedge clk) sclOeN <= 1'b1;
    while (scl !== 1'b1) @(posedge clk);
    half();
  endtask
  task automatic bitOut(input logic b);
    @(posedge clk) sdaOeN <= b;
    half();
    sclUp();
    ack = sda;
    @(posedge clk) sclOeN <= 1'b0;
  endtask
  task automatic sendStart();
    @(posedge clk) sdaOeN <= 1'b0;
    half();
    @(posedge clk) sclOeN <= 1'b0;
    half();
  endtask
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bitOut(b[i]);
    bitOut(1'b1);
  endtask
  task automatic sendStop();
    @(posedge clk) sdaOeN <= 1'b0;
    half();
    sclUp();
    @(posedge clk) sdaOeN <= 1'b1;
    half();
  endtask
  task automatic pullSda(input logic v);
    @(posedge clk) sdaOeN <= v;
  endtask
endmodule // twis_peer
`default_nettype wire

/* testbench.sv */
// Testbench of the two-wire controller with a peer bus master.
`timescale 1ns/100ps
`default_nettype none
`include "twis_consts.vh"
module testbench;
  localparam logic [7:0] SA = `TWIS_OFF_SLAVE_ADDR;
  localparam logic [7:0] BR = `TWIS_OFF_BIT_RATE;
  localparam logic [7:0] CT = `TWIS_OFF_PRIMARY_CTL;
  localparam logic [7:0] ST = `TWIS_OFF_STATUS;
  localparam logic [7:0] DA = `TWIS_OFF_DATA;
  localparam logic [7:0] EX = `TWIS_OFF_ADDR_EXT;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r;
  logic [8:0]  bits;
  realtime     tf;
  int          n_fail = 0;
  int          checks = 0;
  logic [7:0]  ex [3] = '{8'h00, 8'h80, 8'h42};
  logic [7:0]  by [3] = '{8'h00, 8'h00, 8'hf2};
  logic [7:0]  st [3] = '{8'h00, 8'h42, 8'h02};
  wire         hready, hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, irq, pScl, pSda;
  wire  [31:0] hrdata;
  wire         scl = (sclOe | sclOut) & pScl;
  wire         sda = (sdaOe | sdaOut) & pSda;
  assign hready = hreadyout;
  always #2.5 clk = ~clk;

  twis_ctrl twis_ctrl_inst (
    .clk, .rst, .clkEn(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut,
    .sdaOe, .irq
  );
  twis_peer twis_peer_inst (.clk, .scl, .sda, .sclOeN(pScl), .sdaOeN(pSda));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    ahb(1'b0, a, 8'h00);
    chk({r[31:8], r[7:0] & m}, {24'h0, e});
  endtask
  task automatic irqIs(input logic e);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic irqWait();
    while (irq !== 1'b1) @(posedge clk);
    // Lets the pin synchroniser pass the last SCL fall so status bits are settled.
    repeat (8) @(posedge clk);
  endtask
  task automatic wl(input logic v);
    while (scl !== v) @(posedge clk);
  endtask

  initial
  begin
    #400000;
    n_fail++;
    end_sim();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc(ST, 8'h80, 8'hff);
    rc(CT, 8'h00, 8'hff);
    rc(EX, `TWIS_RST_BYTE, 8'hff);
    rc(8'h18, 8'h00, 8'hff);
    irqIs(1'b0);
    wr(BR, 8'h43);
    rc(BR, 8'h43, 8'hff);
    wr(EX, 8'hff);
    rc(EX, 8'hc7, 8'hff);
    wr(EX, 8'h00);
    wr(SA, 8'ha4);
    rc(SA, 8'ha4, 8'hfe);
    wr(CT, 8'hc0);
    rc(CT, 8'hc0, 8'hff);
    twis_peer_inst.sendStart();
    twis_peer_inst.sendByte(8'ha4);
    chk({31'h0, twis_peer_inst.ack}, 32'h0);
    irqWait();
    rc(ST, 8'he2, 8'he6);
    wr(CT, 8'hc0);
    rc(DA, 8'ha4, 8'hff);
    wr(ST, 8'h02);
    irqIs(1'b0);
    twis_peer_inst.sendStop();
    for (int g = 0; g < 3; g++)
    begin
      wr(EX, ex[g]);
      twis_peer_inst.sendStart();
      twis_peer_inst.sendByte(by[g]);
      chk({31'h0, twis_peer_inst.ack}, {31'h0, !st[g][1]});
      if (st[g][1])
        irqWait();
      rc(ST, st[g], g == 2 ? 8'h02 : 8'h42);
      if (g == 1)
        rc(DA, 8'h00, 8'hff);
      wr(ST, 8'h02);
      twis_peer_inst.sendStop();
    end
    wr(EX, 8'h00);
    twis_peer_inst.sendStart();
    rc(ST, 8'h20, 8'h20);
    wr(CT, 8'he0);
    irqWait();
    rc(ST, 8'h12, 8'h12);
    rc(CT, 8'hc0, 8'hf0);
    wr(ST, 8'h00);
    rc(ST, 8'h12, 8'h12);
    wr(CT, 8'h80);
    irqIs(1'b0);
    wr(ST, 8'h12);
    rc(ST, 8'h00, 8'h12);
    twis_peer_inst.sendStop();
    wr(CT, 8'hc4);
    irqWait();
    irqIs(1'b1);
    rc(ST, 8'h12, 8'h12);
    wr(ST, 8'h12);
    wr(CT, 8'hf0);
    wr(DA, 8'h5a);
    wl(1'b0);
    for (int i = 0; i < 9; i++)
    begin
      wl(1'b1);
      if (i == 1)
        chk(32'($realtime - tf), 32'd40);
      bits = {bits[7:0], sda};
      wl(1'b0);
      tf = $realtime;
    end
    irqWait();
    chk({23'h0, bits}, {23'h0, 8'h5a, 1'b1});
    rc(ST, 8'h83, 8'h83);
    wr(ST, 8'h02);
    wr(CT, 8'hc0);
    while (!(scl === 1'b1 && sda === 1'b1)) @(posedge clk);
    do ahb(1'b0, ST, 8'h00); while (r[5] !== 1'b0);
    wr(CT, 8'hf0);
    wr(DA, 8'hff);
    wl(1'b0);
    twis_peer_inst.pullSda(1'b0);
    irqWait();
    rc(ST, 8'h12, 8'h12);
    rc(CT, 8'hc0, 8'hf0);
    chk({31'h0, sdaOe}, 32'h1);
    twis_peer_inst.pullSda(1'b1);
    wr(ST, 8'h12);
    end_sim();
  end
endmodule // testbench

bind twis_ctrl twis_ctrl_chk twis_ctrl_chk_inst (
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .sclOut, .sclOe, .sdaOut, .sdaOe, .irq
);
`default_nettype wire
